// [kstrg_consts.vh]
// Constants for the keyswitch and trigger-output block
//------------------------------------------------------------
// What this block does
// - A short keyswitch press while disarmed arms away.
// - A press held past three seconds arms stay, bypassing zone types 4 and 10.
// - When armed, the next keyswitch short disarms.
// - Tamper loop opening locks out the keyswitch until a console disarm.
// - Keyswitch in use forces its input zone to zone type 10.
// - LEDs: off/off, green ready, red steady, slow flash, rapid flash.
// - Keyswitch option turns alarm triggers into arm and ready indicators.
// - Keyswitch acts only on the configured partition.
// - Keyswitch open/close events report user number zero when enabled.
// - Line is seized off hook before the ground-start trigger is raised.
// - Ground-start trigger drops once dial tone is detected.
// - Trigger one defaults to ground start; one function active at a time.
// - Trigger-one function value 2 selects the remote sounder.
// - Triggers three and four: fire and panic, or armed and ready.
// - Sounder mirrors the partition's console sounds except key clicks.
// - Sounder follows keyswitch partition; keyswitch zone type still forced.
// - Trigger outputs other than the ground-start trigger are enabled per partition by configuration.
// - At most sixteen relay-type outputs are controlled.
// - A relay module answers only when its address is enabled.
//------------------------------------------------------------
`ifndef KSTRG_CONSTS_VH
`define KSTRG_CONSTS_VH

// Register offsets
`define KSTRG_OFF_CTRL 8'h00
`define KSTRG_OFF_PARTEN 8'h04
`define KSTRG_OFF_RLYEN 8'h08
`define KSTRG_OFF_RLYREQ 8'h0C
`define KSTRG_OFF_STATUS 8'h10
`define KSTRG_OFF_EVENT 8'h14

// Control fields
`define KSTRG_CTRL_FUNC_LO 0
`define KSTRG_CTRL_KSEN 2
`define KSTRG_CTRL_OCREP 3
`define KSTRG_CTRL_PART_LO 4
`define KSTRG_CTRL_KEYMODE 7
`define KSTRG_CTRL_RESET 8'h00

// Event register clear bit
`define KSTRG_EVT_VALID 31

// Trigger-one functions
`define KSTRG_FN_GSTART 2'h0
`define KSTRG_FN_OPENCLOSE 2'h1
`define KSTRG_FN_SOUNDER 2'h2

// Event kinds
`define KSTRG_EV_AWAY 2'h1
`define KSTRG_EV_STAY 2'h2
`define KSTRG_EV_DISARM 2'h3
`define KSTRG_KS_USER 8'h00

// Zone types
`define KSTRG_ZT_INTERIOR 4
`define KSTRG_ZT_INT_DELAY 10
`define KSTRG_ZT_KEYSW 4'hA

// Timing
`define KSTRG_CLK_MHZ 100
`define KSTRG_HOLD_MS 3000
`define KSTRG_SLOW_MS 500
`define KSTRG_RAPID_MS 125

`endif

// [kstrg_keyswitch_trigger.v]
// Keyswitch arming, trigger connector outputs and relay enables
`timescale 1ns/1ps
`default_nettype none
`include "kstrg_consts.vh"

module kstrg_keyswitch_trigger #(
    parameter PART_N = 8,
    parameter RELAY_N = 16,
    parameter [31:0] HOLD_CYC = `KSTRG_HOLD_MS * `KSTRG_CLK_MHZ * 1000,
    parameter [31:0] SLOW_CYC = `KSTRG_SLOW_MS * `KSTRG_CLK_MHZ * 1000,
    parameter [31:0] RAPID_CYC = `KSTRG_RAPID_MS * `KSTRG_CLK_MHZ * 1000
) (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    input wire ksShort,
    input wire ksTamperOpen,
    input wire consoleDisarm,
    input wire zoneReady,
    input wire alarmMemory,
    input wire msgRequest,
    input wire dialTone,
    input wire msgDone,
    input wire openCloseTrig,
    input wire consoleSound,
    input wire keyClick,
    input wire [2:0] soundPartition,
    input wire fireTrig,
    input wire panicTrig,
    input wire auxTrig,
    input wire [2:0] alarmPartition,
    output reg armAway,
    output reg armStay,
    output reg disarm,
    output reg [2:0] ksPartition,
    output reg [15:0] bypassTypes,
    output reg ksZoneForce,
    output reg [3:0] ksZoneType,
    output reg evtReport,
    output reg [1:0] evtKind,
    output reg [7:0] evtUser,
    output reg offHook,
    output reg [3:0] trigger_connector,
    output reg [RELAY_N-1:0] relayOut
);

    // Keyswitch states
    localparam [3:0] S_DIS = 4'h1;
    localparam [3:0] S_TIME = 4'h2;
    localparam [3:0] S_HOLD = 4'h4;
    localparam [3:0] S_ARMED = 4'h8;

    // Line states
    localparam [3:0] G_IDLE = 4'h1;
    localparam [3:0] G_SEIZE = 4'h2;
    localparam [3:0] G_GROUND = 4'h4;
    localparam [3:0] G_DIAL = 4'h8;

    //------------------------------------------------------------
    // Register file
    //------------------------------------------------------------
    reg [7:0] ctrl_reg;
    reg [PART_N-1:0] partEn_reg;
    reg [RELAY_N-1:0] relayEn_reg;
    reg [RELAY_N-1:0] relayReq_reg;
    reg evtValid_reg;
    reg [1:0] evtKind_reg;

    reg [3:0] ks_reg;
    reg [3:0] ks_next;
    reg stay_reg;
    reg lockout_reg;
    reg shortPrev_reg;
    reg [31:0] holdCnt_reg;

    reg [3:0] gs_reg;
    reg [3:0] gs_next;
    reg [31:0] flashCnt_reg;
    reg slowPh_reg;
    reg [1:0] rapidDiv_reg;

    reg [31:0] rdMux;
    reg rdErr;
    reg evtPulse;
    reg [1:0] evtPulseKind;

    wire [1:0] trigFunc = ctrl_reg[`KSTRG_CTRL_FUNC_LO +: 2];
    wire ksEnable = ctrl_reg[`KSTRG_CTRL_KSEN];
    wire ocReport = ctrl_reg[`KSTRG_CTRL_OCREP];
    wire [2:0] ksPart = ctrl_reg[`KSTRG_CTRL_PART_LO +: 3];
    wire keyMode = ctrl_reg[`KSTRG_CTRL_KEYMODE] | ksEnable;
    wire sounderMode = (trigFunc == `KSTRG_FN_SOUNDER);
    wire wrAcc = psel & penable & pwrite;
    wire setup = psel & ~penable;
    wire shortRise = ksShort & ~shortPrev_reg;
    wire ksActive = ksEnable & ~lockout_reg;
    wire holdDone = (holdCnt_reg >= HOLD_CYC - 32'h1);
    wire evtClr = wrAcc & (paddr == `KSTRG_OFF_EVENT) &
        pwdata[`KSTRG_EVT_VALID];

    // Access phase completes at once; read data is captured in setup
    assign pready = psel & penable;

    // Read mux; unmapped offsets flag a slave error
    always @* begin
        rdErr = 1'b0;
        rdMux = 32'h00000000;

        case (paddr)
            `KSTRG_OFF_CTRL: rdMux[7:0] = ctrl_reg;
            `KSTRG_OFF_PARTEN: rdMux[PART_N-1:0] = partEn_reg;
            `KSTRG_OFF_RLYEN: rdMux[RELAY_N-1:0] = relayEn_reg;
            `KSTRG_OFF_RLYREQ: rdMux[RELAY_N-1:0] = relayReq_reg;
            `KSTRG_OFF_STATUS: rdMux[11:0] = {trigger_connector, 1'b0,
                offHook, lockout_reg, stay_reg, ks_reg};
            `KSTRG_OFF_EVENT: rdMux = {evtValid_reg, 21'h000000,
                evtKind_reg, `KSTRG_KS_USER};
            default: rdErr = 1'b1;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            ctrl_reg <= `KSTRG_CTRL_RESET;
            partEn_reg <= {PART_N{1'b1}};
            relayEn_reg <= {RELAY_N{1'b0}};
            relayReq_reg <= {RELAY_N{1'b0}};
        end else begin
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rdMux;
                pslverr <= rdErr;
            end

            // Writes land only in the access phase
            if (wrAcc) begin
                case (paddr)
                    `KSTRG_OFF_CTRL: ctrl_reg <= pwdata[7:0];
                    `KSTRG_OFF_PARTEN: partEn_reg <= pwdata[PART_N-1:0];
                    `KSTRG_OFF_RLYEN: relayEn_reg <= pwdata[RELAY_N-1:0];
                    `KSTRG_OFF_RLYREQ: relayReq_reg <= pwdata[RELAY_N-1:0];
                    default: ;
                endcase
            end
        end
    end

    //------------------------------------------------------------
    // Keyswitch arming
    //------------------------------------------------------------
    always @* begin
        ks_next = ks_reg;
        evtPulse = 1'b0;
        evtPulseKind = 2'h0;

        case (ks_reg)
            S_DIS: begin
                if (ksActive & shortRise) begin
                    ks_next = S_TIME;
                end
            end
            S_TIME: begin
                if (!ksActive) begin
                    ks_next = S_DIS;
                end else if (!ksShort) begin
                    ks_next = S_ARMED;
                    evtPulse = 1'b1;
                    evtPulseKind = `KSTRG_EV_AWAY;
                end else if (holdDone) begin
                    ks_next = S_HOLD;
                    evtPulse = 1'b1;
                    evtPulseKind = `KSTRG_EV_STAY;
                end
            end
            S_HOLD: begin
                if (!ksShort) begin
                    ks_next = S_ARMED;
                end
            end
            S_ARMED: begin
                if (ksActive & shortRise) begin
                    ks_next = S_DIS;
                    evtPulse = 1'b1;
                    evtPulseKind = `KSTRG_EV_DISARM;
                end
            end
            default: ks_next = S_DIS;
        endcase
        // A console disarm ends any press with no event
        if (consoleDisarm) begin
            ks_next = S_DIS;
            evtPulse = 1'b0;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ks_reg <= S_DIS;
            stay_reg <= 1'b0;
            lockout_reg <= 1'b0;
            shortPrev_reg <= 1'b0;
            holdCnt_reg <= 32'h00000000;
            armAway <= 1'b0;
            armStay <= 1'b0;
            disarm <= 1'b0;
            bypassTypes <= 16'h0000;
            ksPartition <= 3'h0;
            ksZoneForce <= 1'b0;
            ksZoneType <= 4'h0;
            evtReport <= 1'b0;
            evtKind <= 2'h0;
            evtUser <= 8'h00;
            evtValid_reg <= 1'b0;
            evtKind_reg <= 2'h0;
        end else begin
            ks_reg <= ks_next;
            shortPrev_reg <= ksShort;

            // Tamper open wins over a console disarm in the same cycle
            if (ksEnable & ksTamperOpen) begin
                lockout_reg <= 1'b1;
            end else if (consoleDisarm) begin
                lockout_reg <= 1'b0;
            end
            if (ks_reg == S_TIME) begin
                holdCnt_reg <= holdCnt_reg + 32'h1;
            end else begin
                holdCnt_reg <= 32'h00000000;
            end

            if (evtPulse && evtPulseKind == `KSTRG_EV_STAY) begin
                stay_reg <= 1'b1;
            end else if (ks_next == S_DIS) begin
                stay_reg <= 1'b0;
            end

            armAway <= evtPulse & (evtPulseKind == `KSTRG_EV_AWAY);
            armStay <= evtPulse & (evtPulseKind == `KSTRG_EV_STAY);
            disarm <= evtPulse & (evtPulseKind == `KSTRG_EV_DISARM);
            // Stay arming bypasses the interior zone types
            if (evtPulse && evtPulseKind == `KSTRG_EV_STAY) begin
                bypassTypes <= (16'h0001 << `KSTRG_ZT_INTERIOR) |
                    (16'h0001 << `KSTRG_ZT_INT_DELAY);
            end else begin
                bypassTypes <= 16'h0000;
            end

            ksPartition <= ksPart;
            ksZoneForce <= ksEnable | sounderMode;
            ksZoneType <= (ksEnable | sounderMode) ?
                `KSTRG_ZT_KEYSW : 4'h0;

            evtReport <= evtPulse & ocReport;
            evtKind <= evtPulse ? evtPulseKind : 2'h0;
            evtUser <= `KSTRG_KS_USER;

            // A new event wins over a software clear
            if (evtPulse & ocReport) begin
                evtValid_reg <= 1'b1;
                evtKind_reg <= evtPulseKind;
            end else if (evtClr) begin
                evtValid_reg <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // Ground-start line sequence
    //------------------------------------------------------------
    always @* begin
        gs_next = gs_reg;

        // With the ground-start function, trigger one is raised only in G_GROUND
        case (gs_reg)
            G_IDLE: if (msgRequest && trigFunc == `KSTRG_FN_GSTART) begin
                gs_next = G_SEIZE;
            end
            G_SEIZE: gs_next = G_GROUND;
            G_GROUND: if (dialTone) begin
                gs_next = G_DIAL;
            end
            G_DIAL: if (msgDone) begin
                gs_next = G_IDLE;
            end
            default: gs_next = G_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            gs_reg <= G_IDLE;
            offHook <= 1'b0;
        end else begin
            gs_reg <= gs_next;
            offHook <= (gs_next != G_IDLE);
        end
    end

    //------------------------------------------------------------
    // LED flash timing
    //------------------------------------------------------------
    // Rapid phase flips each period, slow phase every fourth
    always @(posedge clk) begin
        if (rst) begin
            flashCnt_reg <= 32'h00000000;
            slowPh_reg <= 1'b0;
            rapidDiv_reg <= 2'h0;
        end else if (flashCnt_reg >= RAPID_CYC - 32'h1) begin
            flashCnt_reg <= 32'h00000000;
            rapidDiv_reg <= rapidDiv_reg + 2'h1;
            if (rapidDiv_reg == 2'h3) begin
                slowPh_reg <= ~slowPh_reg;
            end
        end else begin
            flashCnt_reg <= flashCnt_reg + 32'h1;
        end
    end

    //------------------------------------------------------------
    // Trigger connector and relays
    //------------------------------------------------------------
    wire armed = (ks_reg == S_ARMED) | (ks_reg == S_HOLD);
    wire alarmOk = partEn_reg[alarmPartition];
    wire ksPartOk = partEn_reg[ksPart];

    reg redLed;
    reg greenLed;
    reg trigOne;

    always @* begin
        // Alarm memory takes precedence over the armed patterns
        if (alarmMemory) begin
            redLed = rapidDiv_reg[0];
        end else if (armed & stay_reg) begin
            redLed = slowPh_reg;
        end else begin
            redLed = armed;
        end
        greenLed = ~armed & zoneReady;

        case (trigFunc)
            `KSTRG_FN_GSTART: trigOne = (gs_reg == G_GROUND);
            `KSTRG_FN_OPENCLOSE: trigOne = openCloseTrig & ksPartOk;
            `KSTRG_FN_SOUNDER: trigOne = consoleSound & ~keyClick &
                (soundPartition == ksPart) & ksPartOk;
            default: trigOne = 1'b0;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            trigger_connector <= 4'h0;
            relayOut <= {RELAY_N{1'b0}};
        end else begin
            // Trigger two is the aux alarm, idle while the keyswitch is enabled
            trigger_connector[0] <= trigOne;
            trigger_connector[1] <= ~ksEnable & auxTrig & alarmOk;
            trigger_connector[2] <= keyMode ? (ksPartOk & redLed) :
                (fireTrig & alarmOk);
            trigger_connector[3] <= keyMode ? (ksPartOk & greenLed) :
                (panicTrig & alarmOk);

            relayOut <= relayReq_reg & relayEn_reg;
        end
    end

endmodule
`default_nettype wire

// [kstrg_far_side.sv]
// Far-side model: ground-start module and exchange giving dial tone
`timescale 1ns/1ps
`default_nettype none
module kstrg_far_side (
    input wire logic clk,
    input wire logic rst,
    input wire logic offHook,
    input wire logic gsTrig,
    input wire logic [3:0] toneDelay,
    output logic dialTone,
    output logic ringGround
);
    logic [3:0] waitCnt;
    // Ring is grounded only while the trigger is raised
    assign ringGround = gsTrig;
    always @(posedge clk) begin
        if (rst || !offHook) begin
            waitCnt <= 4'h0;
            dialTone <= 1'b0;
        end else if (ringGround && !dialTone) begin
            // Tone starts only on a seized line with ring grounded, then holds until the line goes on hook
            if (waitCnt == toneDelay) begin
                dialTone <= 1'b1;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [kstrg_keyswitch_trigger_sva.sv]
// Concurrent checks on the keyswitch and trigger-output block ports
`timescale 1ns/1ps
`default_nettype none
module kstrg_keyswitch_trigger_sva (
    input wire clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire ksShort,
    input wire ksTamperOpen,
    input wire consoleDisarm,
    input wire dialTone,
    input wire armAway,
    input wire armStay,
    input wire disarm,
    input wire [15:0] bypassTypes,
    input wire ksZoneForce,
    input wire [3:0] ksZoneType,
    input wire evtReport,
    input wire [1:0] evtKind,
    input wire [7:0] evtUser,
    input wire offHook,
    input wire [3:0] trigger_connector
);
    logic lockedOut;
    always @(posedge clk) begin
        if (rst)
            lockedOut <= 1'b0;
        else if (ksTamperOpen)
            lockedOut <= 1'b1;
        else if (consoleDisarm)
            lockedOut <= 1'b0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    apb_ready_a: assert property (pready == (psel && penable))
        else $error("pready not equal to psel and penable");
    away_pulse_a: assert property (armAway |=> !armAway && !disarm)
        else $error("away pulse longer than one cycle");
    stay_bypass_a: assert property (
        armStay |-> bypassTypes[4] && bypassTypes[10])
        else $error("stay arming without zone type bypass");
    disarm_alone_a: assert property (disarm |-> !armAway && !armStay)
        else $error("disarm together with arming");
    tamper_lock_a: assert property (
        lockedOut && $past(lockedOut, 3) |-> !(armAway || armStay || disarm))
        else $error("keyswitch acted while locked out");
    zone_force_a: assert property (ksZoneForce |-> ksZoneType == 4'hA)
        else $error("forced zone type is not ten");
    event_user_a: assert property (
        evtReport |-> evtUser == 8'h00 && evtKind != 2'h0)
        else $error("event without user zero or kind");
    seize_first_a: assert property (
        $rose(offHook) |-> !trigger_connector[0] ##1 !trigger_connector[0]
        ##1 trigger_connector[0])
        else $error("ground start not raised right after seizing");
    tone_drop_a: assert property (
        offHook && trigger_connector[0] && dialTone
        |-> ##[1:2] !trigger_connector[0])
        else $error("ground start held after dial tone");
    stay_held_a: assert property (armStay |-> $past(ksShort))
        else $error("stay arming without a held short");
    away_release_a: assert property (armAway |-> !$past(ksShort))
        else $error("away arming while short still held");
    cover property (armAway);
    cover property (armStay);
    cover property (offHook && $fell(trigger_connector[0]));
endmodule
bind kstrg_keyswitch_trigger kstrg_keyswitch_trigger_sva chk (.clk, .rst,
    .psel, .penable, .pready, .ksShort, .ksTamperOpen, .consoleDisarm,
    .dialTone, .armAway, .armStay, .disarm, .bypassTypes, .ksZoneForce,
    .ksZoneType, .evtReport, .evtKind, .evtUser, .offHook, .trigger_connector);
`default_nettype wire

// [kstrg_keyswitch_trigger_tb_top.sv]
// Self-checking bench for the keyswitch and trigger-output block
`timescale 1ns/1ps
`default_nettype none
`include "kstrg_consts.vh"
module kstrg_keyswitch_trigger_tb_top;
    localparam int HOLD = 50;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, errSeen;
    logic [7:0] paddr, pen;
    logic [31:0] pwdata, prdata, rdData, seed;
    logic ksShort, ksTamperOpen, consoleDisarm, zoneReady, alarmMemory;
    logic msgRequest, dialTone, msgDone, openCloseTrig, consoleSound, keyClick;
    logic fireTrig, panicTrig, auxTrig, armAway, armStay, disarm, exp0;
    logic ksZoneForce, evtReport, offHook, ringGround;
    logic [2:0] soundPartition, alarmPartition, ksPartition;
    logic [15:0] bypassTypes, relayOut;
    logic [3:0] ksZoneType, trigger_connector, toneDelay;
    logic [1:0] evtKind, lastKind;
    logic [7:0] evtUser;
    int fail_count, compares, cycles, awayCnt, stayCnt, disCnt, n, t;
    kstrg_keyswitch_trigger #(.HOLD_CYC(HOLD), .RAPID_CYC(4)) dut (.clk, .rst,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
        .ksShort, .ksTamperOpen, .consoleDisarm, .zoneReady, .alarmMemory,
        .msgRequest, .dialTone, .msgDone, .openCloseTrig, .consoleSound,
        .keyClick, .soundPartition, .fireTrig, .panicTrig, .auxTrig,
        .alarmPartition, .armAway, .armStay, .disarm, .ksPartition,
        .bypassTypes, .ksZoneForce, .ksZoneType, .evtReport, .evtKind,
        .evtUser, .offHook, .trigger_connector, .relayOut);
    kstrg_far_side far (.clk, .rst, .offHook, .gsTrig(trigger_connector[0]),
        .toneDelay, .dialTone, .ringGround);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (armAway === 1'b1) awayCnt++;
        if (armStay === 1'b1) stayCnt++;
        if (disarm === 1'b1) disCnt++;
        if (evtReport === 1'b1) lastKind = evtKind;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string what, input logic [31:0] e,
            input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        int w;
        w = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 16);
        if (w == 16) chk("pready", 1, 0);
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic press(input int k);
        ksShort <= 1'b1;
        tick(k);
        ksShort <= 1'b0;
        tick(8);
    endtask
    task automatic redToggles(input int k);
        logic prev;
        t = 0;
        prev = trigger_connector[2];
        repeat (k) begin
            @(posedge clk);
            if (trigger_connector[2] !== prev) t++;
            prev = trigger_connector[2];
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ksShort, ksTamperOpen} = '0;
        {consoleDisarm, zoneReady, alarmMemory, msgRequest, msgDone} = '0;
        {openCloseTrig, consoleSound, keyClick, fireTrig, panicTrig} = '0;
        {auxTrig, soundPartition, alarmPartition, toneDelay} = '0;
        {fail_count, compares, cycles, awayCnt, stayCnt, disCnt} = '0;
        seed = 32'hB51831C3;
        rst = 1'b1;
        tick(16);
        rst <= 1'b0;
        tick(1);
        // -------------------------------------------------
        // Register reset values, unmapped access
        // -------------------------------------------------
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", (i == 1) ? 32'hFF : (i == 4) ? 32'h1 : 0,
                rdData);
            chk("slave error", (i == 6) ? 1 : 0, errSeen);
        end
        // -------------------------------------------------
        // Alarm triggers gated by partition enables
        // -------------------------------------------------
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            if (i % 8 == 0) begin
                pen = seed[31:24];
                apb(1'b1, `KSTRG_OFF_PARTEN, {24'h0, pen});
            end
            {panicTrig, fireTrig, auxTrig} <= seed[2:0];
            alarmPartition <= seed[5:3];
            tick(2);
            chk("alarm triggers", {seed[2:0] & {3{pen[seed[5:3]]}}, 1'b0},
                trigger_connector);
        end
        apb(1'b1, `KSTRG_OFF_PARTEN, 32'hFF);
        // -------------------------------------------------
        // Ground start, prompt and slow dial tone
        // -------------------------------------------------
        for (int j = 0; j < 2; j++) begin
            seed = xs(seed);
            toneDelay <= j ? (seed[3:0] | 4'h8) : 4'h0;
            msgRequest <= 1'b1;
            n = 0;
            do begin tick(1); n++; end while (offHook !== 1'b1 && n < 50);
            chk("trigger before seize", 0, trigger_connector[0]);
            do begin tick(1); n++; end while (dialTone !== 1'b1 && n < 80);
            chk("dial tone", 1, dialTone);
            tick(3);
            chk("trigger after tone", 0, trigger_connector[0]);
            chk("line held", 1, offHook);
            msgRequest <= 1'b0;
            msgDone <= 1'b1;
            tick(1);
            msgDone <= 1'b0;
            tick(3);
            chk("line freed", 0, offHook);
        end
        // -------------------------------------------------
        // Other trigger-one functions
        // -------------------------------------------------
        for (int f = 1; f < 4; f++) begin
            apb(1'b1, `KSTRG_OFF_CTRL, 32'(f) | 32'h50);
            msgRequest <= 1'b1;
            alarmPartition <= 3'h5;
            for (int i = 0; i < 12; i++) begin
                seed = xs(seed);
                {openCloseTrig, consoleSound, keyClick} <= seed[2:0];
                soundPartition <= seed[3] ? 3'h5 : seed[6:4];
                tick(2);
                exp0 = (f == 1) ? seed[2] : (f == 2) ? (seed[1] && !seed[0]
                    && (seed[3] || seed[6:4] == 3'h5)) : 1'b0;
                chk("trigger one", exp0, trigger_connector[0]);
                chk("no seize", 0, offHook);
            end
            if (f == 2) chk("sounder zone", 4'hA, ksZoneType);
        end
        msgRequest <= 1'b0;
        // -------------------------------------------------
        // Keyswitch arming, LEDs, tamper, events
        // -------------------------------------------------
        apb(1'b1, `KSTRG_OFF_CTRL, 32'hDC);
        auxTrig <= 1'b1;
        tick(3);
        chk("partition", 3'h5, ksPartition);
        chk("zone type", 4'hA, ksZoneType);
        chk("aux off", 0, trigger_connector[1]);
        chk("leds not ready", 2'b00, trigger_connector[3:2]);
        zoneReady <= 1'b1;
        tick(3);
        chk("leds ready", 2'b10, trigger_connector[3:2]);
        press(5);
        chk("away count", 1, awayCnt);
        chk("away kind", `KSTRG_EV_AWAY, lastKind);
        redToggles(40);
        chk("red steady", 1, t == 0 &&
            trigger_connector[3:2] === 2'b01);
        press(5);
        chk("disarm count", 1, disCnt);
        press(HOLD + 10);
        chk("stay count", 1, stayCnt);
        chk("no away", 1, awayCnt);
        chk("stay kind", `KSTRG_EV_STAY, lastKind);
        redToggles(64);
        chk("slow flash", 1, t >= 3 && t <= 5);
        press(5);
        ksTamperOpen <= 1'b1;
        tick(1);
        ksTamperOpen <= 1'b0;
        press(5);
        chk("locked out", 1, awayCnt);
        consoleDisarm <= 1'b1;
        tick(1);
        consoleDisarm <= 1'b0;
        press(5);
        chk("unlocked", 2, awayCnt);
        press(5);
        chk("disarm kind", `KSTRG_EV_DISARM, lastKind);
        apb(1'b0, `KSTRG_OFF_EVENT, 32'h0);
        chk("event word", 32'h80000300, rdData & 32'h800003FF);
        apb(1'b1, `KSTRG_OFF_EVENT, 32'h80000000);
        apb(1'b0, `KSTRG_OFF_EVENT, 32'h0);
        chk("event cleared", 32'h00000300, rdData);
        zoneReady <= 1'b0;
        alarmMemory <= 1'b1;
        tick(4);
        redToggles(64);
        chk("rapid flash", 1, t >= 14 && t <= 18);
        // -------------------------------------------------
        // Relay outputs need an enabled address
        // -------------------------------------------------
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            apb(1'b1, `KSTRG_OFF_RLYEN, {16'h0, seed[15:0]});
            apb(1'b1, `KSTRG_OFF_RLYREQ, {16'h0, seed[31:16]});
            tick(1);
            chk("relays", seed[15:0] & seed[31:16], relayOut);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
